// ===== hw/tmis_status.sv
// timer interrupt status block: raw, mask, masked and clear registers
`timescale 1ns/1ns

module tmis_status (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire tmis_pkg::tmis_req_t bus_req,
   output logic [31:0] bus_rdata,
   input wire tmis_pkg::tmis_evt_t timer_events,
   output logic timer_irq
);
   import tmis_pkg::*;

   logic [31:0] raw_status;
   logic [31:0] irq_mask;
   logic [31:0] masked_status;
   logic [31:0] event_vec;
   logic [31:0] clear_vec;
   logic [31:0] next_rdata;

   // ************************************************************
   // event mapping
   // ************************************************************
   // place each event strobe at its bit; unused positions stay zero
   always_comb begin
      event_vec = TMIS_READ_ZERO;
      event_vec[TMIS_BIT_TA_TIMEOUT] = timer_events.ta_timeout;
      event_vec[TMIS_BIT_CA_MATCH] = timer_events.ca_match;
      event_vec[TMIS_BIT_CA_EVENT] = timer_events.ca_event;
      event_vec[TMIS_BIT_RTC_EVENT] = timer_events.rtc_event;
      event_vec[TMIS_BIT_TB_TIMEOUT] = timer_events.tb_timeout;
      event_vec[TMIS_BIT_CB_MATCH] = timer_events.cb_match;
      event_vec[TMIS_BIT_CB_EVENT] = timer_events.cb_event;
   end

   // write-one-to-clear strobes; zeros leave the status alone
   assign clear_vec = (bus_req.wr && bus_req.addr == TMIS_OFF_CLEAR) ?
                      (bus_req.wdata & TMIS_IMPL_MASK) : TMIS_READ_ZERO;

   // ************************************************************
   // status registers
   // ************************************************************
   // raw flags latch every event whatever the mask; set beats a
   // simultaneous clear so no event is lost
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_raw
         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               raw_status[gi] <= TMIS_RESET_VAL[gi];
            end else if (TMIS_IMPL_MASK[gi] && event_vec[gi]) begin
               raw_status[gi] <= 1'b1;
            end else if (clear_vec[gi]) begin
               raw_status[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // mask register, one enables a source
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_mask <= TMIS_RESET_VAL;
      end else if (bus_req.wr && bus_req.addr == TMIS_OFF_MASK) begin
         irq_mask <= bus_req.wdata & TMIS_IMPL_MASK;
      end
   end

   // masked view is combinational so it tracks mask changes at once
   assign masked_status = raw_status & irq_mask;
   assign timer_irq = |masked_status;

   // ************************************************************
   // register read port
   // ************************************************************
   // read decode; writes to the masked offset are ignored and reads
   // have no side effects on any flag
   always_comb begin
      next_rdata = TMIS_READ_ZERO;
      if (bus_req.rd) begin
         case (bus_req.addr)
            TMIS_OFF_MASK: next_rdata = irq_mask;
            TMIS_OFF_RAW: next_rdata = raw_status;
            TMIS_OFF_MASKED: next_rdata = masked_status;
            default: next_rdata = TMIS_READ_ZERO; // clear and unmapped read zero
         endcase
      end
   end

   // read data stands one cycle after the strobe only
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bus_rdata <= TMIS_READ_ZERO;
      end else begin
         bus_rdata <= next_rdata;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   sequence s_clear_write(int b);
      bus_req.wr && bus_req.addr == TMIS_OFF_CLEAR && bus_req.wdata[b];
   endsequence

   // a write to the mask offset in this cycle
   sequence s_mask_write;
      bus_req.wr && bus_req.addr == TMIS_OFF_MASK;
   endsequence

   // a cycle with no event strobe and no write, only reads or idle
   sequence s_quiet;
      timer_events == '0 && !bus_req.wr;
   endsequence

   // reset seen low on two edges in a row, so the async reset has acted
   sequence s_held_reset;
      !nrst ##1 !nrst;
   endsequence

   property p_no_set_masked;
      @(posedge sys_clk) disable iff (!nrst)
      !irq_mask[TMIS_BIT_CA_MATCH] |-> !masked_status[TMIS_BIT_CA_MATCH];
   endproperty
   a_no_set_masked: assert property (p_no_set_masked)
      else $error("masked flag set while source disabled");

   property p_clear_only_by_write;
      @(posedge sys_clk) disable iff (!nrst)
      $fell(raw_status[TMIS_BIT_CA_EVENT]) |->
         $past(bus_req.wr) && $past(bus_req.addr) == TMIS_OFF_CLEAR &&
         $past(bus_req.wdata[TMIS_BIT_CA_EVENT]);
   endproperty
   a_clear_only_by_write: assert property (p_clear_only_by_write)
      else $error("flag cleared without a clear write");

   property p_camatch_pos;
      @(posedge sys_clk) disable iff (!nrst)
      // a mask write in the same cycle may legally disable the source
      timer_events.ca_match && irq_mask[TMIS_BIT_CA_MATCH] &&
         !(bus_req.wr && bus_req.addr == TMIS_OFF_MASK) |=>
         masked_status[TMIS_BIT_CA_MATCH];
   endproperty
   a_camatch_pos: assert property (p_camatch_pos)
      else $error("capture match flag not at its bit");

   property p_caevent_pos;
      @(posedge sys_clk) disable iff (!nrst)
      timer_events.ca_event |=> raw_status[TMIS_BIT_CA_EVENT];
   endproperty
   a_caevent_pos: assert property (p_caevent_pos)
      else $error("capture event flag not at its bit");

   property p_masked_read;
      @(posedge sys_clk) disable iff (!nrst)
      bus_req.rd && bus_req.addr == TMIS_OFF_MASKED |=>
         bus_rdata == $past(masked_status);
   endproperty
   a_masked_read: assert property (p_masked_read)
      else $error("masked status read mismatch");

   property p_reserved_zero;
      @(posedge sys_clk) disable iff (!nrst)
      (raw_status & ~TMIS_IMPL_MASK) == TMIS_READ_ZERO &&
         (bus_rdata & ~TMIS_IMPL_MASK) == TMIS_READ_ZERO;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved status bit set");

   property p_raw_unmasked;
      @(posedge sys_clk) disable iff (!nrst)
      timer_events.rtc_event && !irq_mask[TMIS_BIT_RTC_EVENT] |=>
         raw_status[TMIS_BIT_RTC_EVENT];
   endproperty
   a_raw_unmasked: assert property (p_raw_unmasked)
      else $error("raw flag missed while masked");

   property p_irq_level;
      @(posedge sys_clk) disable iff (!nrst)
      timer_irq == ((raw_status & irq_mask) != TMIS_READ_ZERO);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt not equal to enabled flags");

   property p_clear_effect;
      @(posedge sys_clk) disable iff (!nrst)
      s_clear_write(TMIS_BIT_TB_TIMEOUT) ##0 !timer_events.tb_timeout |=>
         !raw_status[TMIS_BIT_TB_TIMEOUT] ##1 1'b1;
   endproperty
   a_clear_effect: assert property (p_clear_effect)
      else $error("clear write did not clear the flag");

   // each remaining source lands on its own raw bit one cycle later
   property p_ta_pos;
      @(posedge sys_clk) disable iff (!nrst)
      timer_events.ta_timeout |=> raw_status[TMIS_BIT_TA_TIMEOUT];
   endproperty
   a_ta_pos: assert property (p_ta_pos)
      else $error("timer A timeout flag not at its bit");

   property p_rtc_pos;
      @(posedge sys_clk) disable iff (!nrst)
      timer_events.rtc_event |=> raw_status[TMIS_BIT_RTC_EVENT];
   endproperty
   a_rtc_pos: assert property (p_rtc_pos)
      else $error("clock event flag not at its bit");

   property p_tb_pos;
      @(posedge sys_clk) disable iff (!nrst)
      timer_events.tb_timeout |=> raw_status[TMIS_BIT_TB_TIMEOUT];
   endproperty
   a_tb_pos: assert property (p_tb_pos)
      else $error("timer B timeout flag not at its bit");

   property p_cbmatch_pos;
      @(posedge sys_clk) disable iff (!nrst)
      timer_events.cb_match |=> raw_status[TMIS_BIT_CB_MATCH];
   endproperty
   a_cbmatch_pos: assert property (p_cbmatch_pos)
      else $error("capture B match flag not at its bit");

   property p_cbevent_pos;
      @(posedge sys_clk) disable iff (!nrst)
      timer_events.cb_event |=> raw_status[TMIS_BIT_CB_EVENT];
   endproperty
   a_cbevent_pos: assert property (p_cbevent_pos)
      else $error("capture B event flag not at its bit");

   // a mask write lands whole, minus the reserved bits
   property p_mask_write;
      @(posedge sys_clk) disable iff (!nrst)
      s_mask_write |=> irq_mask == ($past(bus_req.wdata) & TMIS_IMPL_MASK);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("mask write did not land");

   // nothing but a mask write moves the mask
   property p_mask_hold;
      @(posedge sys_clk) disable iff (!nrst)
      !(bus_req.wr && bus_req.addr == TMIS_OFF_MASK) |=> $stable(irq_mask);
   endproperty
   a_mask_hold: assert property (p_mask_hold)
      else $error("mask changed without a mask write");

   // with no event and no write the flags stand still; reads are harmless
   property p_quiet_hold;
      @(posedge sys_clk) disable iff (!nrst)
      s_quiet |=> $stable(raw_status);
   endproperty
   a_quiet_hold: assert property (p_quiet_hold)
      else $error("flag moved in a quiet cycle");

   property p_read_harmless;
      @(posedge sys_clk) disable iff (!nrst)
      s_quiet ##0 bus_req.rd && bus_req.addr == TMIS_OFF_MASKED |=>
         $stable(masked_status);
   endproperty
   a_read_harmless: assert property (p_read_harmless)
      else $error("masked read disturbed the flags");

   // read data only in the cycle after a read strobe, zero otherwise
   property p_rdata_idle;
      @(posedge sys_clk) disable iff (!nrst)
      !bus_req.rd |=> bus_rdata == TMIS_READ_ZERO;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside the read cycle");

   // the masked view is read-only: a write there changes nothing
   property p_masked_wr_ignored;
      @(posedge sys_clk) disable iff (!nrst)
      bus_req.wr && bus_req.addr == TMIS_OFF_MASKED && timer_events == '0 |=>
         $stable(raw_status) && $stable(irq_mask);
   endproperty
   a_masked_wr_ignored: assert property (p_masked_wr_ignored)
      else $error("write to the masked view had an effect");

   // flags, mask and read data sit at zero under reset;
   // no disable here, since reset is exactly what this one watches
   property p_reset_zero;
      @(posedge sys_clk)
      s_held_reset |->
         raw_status == TMIS_RESET_VAL && irq_mask == TMIS_RESET_VAL &&
         masked_status == TMIS_RESET_VAL && bus_rdata == TMIS_READ_ZERO && !timer_irq;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("state not at zero under reset");

   // enabling a pending source exposes it one cycle after the mask write
   property p_enable_exposes;
      @(posedge sys_clk) disable iff (!nrst)
      s_mask_write ##0 bus_req.wdata[TMIS_BIT_CA_MATCH] && raw_status[TMIS_BIT_CA_MATCH] |=>
         masked_status[TMIS_BIT_CA_MATCH];
   endproperty
   a_enable_exposes: assert property (p_enable_exposes)
      else $error("pending flag not exposed by the mask");

   // a clear one drops the masked view as well as the raw flag
   property p_clear_masked;
      @(posedge sys_clk) disable iff (!nrst)
      s_clear_write(TMIS_BIT_CA_MATCH) ##0 !timer_events.ca_match |=>
         !masked_status[TMIS_BIT_CA_MATCH];
   endproperty
   a_clear_masked: assert property (p_clear_masked)
      else $error("clear write left the masked flag set");

   // a clear write of zeros leaves every flag alone
   property p_clear_zero_ignored;
      @(posedge sys_clk) disable iff (!nrst)
      bus_req.wr && bus_req.addr == TMIS_OFF_CLEAR && bus_req.wdata == TMIS_READ_ZERO &&
         timer_events == '0 |=> $stable(raw_status);
   endproperty
   a_clear_zero_ignored: assert property (p_clear_zero_ignored)
      else $error("clear write of zeros changed a flag");
endmodule

// ===== hw/tmis_pkg.sv
// package: register map, field layout and bus carrier for the timer interrupt status block
package tmis_pkg;
   // register offsets (byte addresses)
   localparam logic [11:0] TMIS_OFF_MASK = 12'h018;
   localparam logic [11:0] TMIS_OFF_RAW = 12'h01C;
   localparam logic [11:0] TMIS_OFF_MASKED = 12'h020;
   localparam logic [11:0] TMIS_OFF_CLEAR = 12'h024;
   // field positions
   localparam int TMIS_BIT_TA_TIMEOUT = 0;
   localparam int TMIS_BIT_CA_MATCH = 1;
   localparam int TMIS_BIT_CA_EVENT = 2;
   localparam int TMIS_BIT_RTC_EVENT = 3;
   localparam int TMIS_BIT_TB_TIMEOUT = 8;
   localparam int TMIS_BIT_CB_MATCH = 9;
   localparam int TMIS_BIT_CB_EVENT = 10;
   // implemented bits: 10:8 and 3:0, the rest reserved and read as zero
   localparam logic [31:0] TMIS_IMPL_MASK = 32'h0000070F;
   localparam logic [31:0] TMIS_RESET_VAL = 32'h00000000;
   localparam logic [31:0] TMIS_READ_ZERO = 32'h00000000;

   // register bus request from software
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } tmis_req_t;

   // timer event strobes, one cycle each
   typedef struct packed {
      logic cb_event;
      logic cb_match;
      logic tb_timeout;
      logic rtc_event;
      logic ca_event;
      logic ca_match;
      logic ta_timeout;
   } tmis_evt_t;
endpackage

// ===== verification/tmis_tb.sv
// self-checking bench for the timer interrupt status block
`timescale 1ns/1ns
module testbench;
   import tmis_pkg::*;
   // ****************
   // signals and rows
   // ****************
   typedef struct packed {logic [6:0] ev; logic [31:0] mask; logic [31:0] exp;} tmis_row_t;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   tmis_req_t bus_req = '0;
   tmis_evt_t timer_events = '0;
   logic [31:0] bus_rdata;
   logic timer_irq;
   logic [31:0] d;
   int err_count = 0;
   int samples_checked = 0;
   tmis_row_t rows [10] = '{'{7'h01, 32'h1, 32'h1}, '{7'h02, 32'h2, 32'h2},
      '{7'h04, 32'h4, 32'h4}, '{7'h08, 32'h8, 32'h8}, '{7'h10, 32'h100, 32'h100},
      '{7'h20, 32'h200, 32'h200}, '{7'h40, 32'h400, 32'h400}, '{7'h7F, 32'h0, 32'h0},
      '{7'h7F, 32'hFFFFFFFF, 32'h70F}, '{7'h05, 32'h4, 32'h4}};
   tmis_status dut_u (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .timer_events(timer_events), .timer_irq(timer_irq));
   // 8 ns clock
   always #4 sys_clk = ~sys_clk;
   // ****************
   // bus and checks
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1 v = bus_rdata;
   endtask
   task automatic pulse(input logic [6:0] e);
      @(posedge sys_clk);
      timer_events <= e;
      @(posedge sys_clk);
      timer_events <= '0;
   endtask
   task automatic final_report();
      if (err_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      #200000;
      err_count++;
      final_report();
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      chk({31'h0, timer_irq}, 32'h0);
      rd(TMIS_OFF_MASKED, d); chk(d, 32'h0);
      rd(TMIS_OFF_MASK, d); chk(d, 32'h0);
      foreach (rows[i]) begin
         wr(TMIS_OFF_MASK, rows[i].mask);
         pulse(rows[i].ev);
         rd(TMIS_OFF_MASKED, d); chk(d, rows[i].exp);
         chk({31'h0, timer_irq}, {31'h0, |rows[i].exp});
         rd(TMIS_OFF_RAW, d); chk(d, {21'h0, rows[i].ev[6:4], 4'h0, rows[i].ev[3:0]});
         rd(TMIS_OFF_MASK, d); chk(d, rows[i].mask & 32'h70F);
         wr(TMIS_OFF_CLEAR, 32'hFFFFFFFF);
         rd(TMIS_OFF_RAW, d); chk(d, 32'h0);
      end
      // pending while masked, then exposed by the mask; only a clear one removes it
      wr(TMIS_OFF_MASK, 32'h0);
      pulse(7'h02);
      rd(TMIS_OFF_MASKED, d); chk(d, 32'h0);
      rd(TMIS_OFF_RAW, d); rd(TMIS_OFF_RAW, d); chk(d, 32'h2);
      wr(TMIS_OFF_MASKED, 32'hFFFFFFFF); wr(TMIS_OFF_CLEAR, 32'h0);
      rd(TMIS_OFF_RAW, d); chk(d, 32'h2);
      wr(TMIS_OFF_MASK, 32'h2);
      rd(TMIS_OFF_MASKED, d); chk(d, 32'h2);
      chk({31'h0, timer_irq}, 32'h1);
      wr(TMIS_OFF_CLEAR, 32'h2);
      rd(TMIS_OFF_MASKED, d); chk(d, 32'h0);
      rd(12'h100, d); chk(d, 32'h0);
      // reset in mid-run wipes flags and mask
      pulse(7'h02);
      @(posedge sys_clk); nrst <= 1'b0;
      repeat (2) @(posedge sys_clk); nrst <= 1'b1;
      chk({31'h0, timer_irq}, 32'h0);
      rd(TMIS_OFF_MASK, d); chk(d, 32'h0);
      rd(TMIS_OFF_MASKED, d); chk(d, 32'h0);
      final_report();
   end
endmodule
